// *** src/cgpd_pkg.sv ***
/*
 * Constants, types and states for the clock generator power-down block.
 * Assumes one 100 MHz clock (mclk) and synchronous inputs.
 */
// Overview of operation
// - Power down only after two low samples in a row at complement rises.
// - On entry each non-host output stops once low, after any high phase, then stays low.
// - When down, true host drives high at 2x current; complement released.
// - Entry works the same way for every host clock frequency setting.
// - Non-host outputs go quiet within less than one of their cycles.
// - Once power_down_n is high again, clocks resume just after a 3 ms wake count.
package cgpd_pkg;
    localparam int       N_OUT        = 4;  // Ref, usb, agp, pci
    localparam int       DIV_W        = 8;
    // Half-period counts of mclk, one per host frequency setting
    localparam logic [7:0] HOST_HALF_66  = 8'h03;
    localparam logic [7:0] HOST_HALF_100 = 8'h02;
    localparam logic [7:0] HOST_HALF_133 = 8'h02;
    localparam logic [7:0] HOST_HALF_200 = 8'h01;
    localparam logic [1:0] SEL_66  = 2'h0;
    localparam logic [1:0] SEL_100 = 2'h1;
    localparam logic [1:0] SEL_133 = 2'h2;
    localparam logic [1:0] SEL_200 = 2'h3;
    // Half-period counts of the other outputs, index 0 is ref
    localparam logic [N_OUT*DIV_W-1:0] OUT_HALF = 32'h0f_04_03_07;
    // Bound allowed for the quiet time of the other outputs, in mclk cycles
    localparam int       QUIET_MAX    = 520;
    // Power-up latency, less than the printed limit
    localparam int       CLK_PERIOD_NS = 10;
    localparam int       PUP_LAT_MS    = 3;
    localparam int       PUP_LAT_CYC   =
        PUP_LAT_MS * 1000000 / CLK_PERIOD_NS - 1;
    localparam int       LAT_W        = 20;

    typedef enum logic [1:0] {
        CGPD_RUN,
        CGPD_STOPPING,
        CGPD_DOWN,
        CGPD_WAKE
    } cgpd_state_t;

    typedef struct packed {
        logic t;          // True host clock
        logic c;          // Complement host clock
        logic c_oe_n;     // Low while complement is driven
        logic t_dbl_iref; // High: true side at twice reference current
    } cgpd_host_pins_t;
endpackage : cgpd_pkg

// *** src/cgpd_clk_div.sv ***
/*
 * Parkable clock divider: toggles every half count of mclk and parks low.
 * Assumes half is at least one and holds steady while running.
 */
`timescale 1ns/1ps
module cgpd_clk_div (
    input  wire logic                      mclk,
    input  wire logic                      srst,
    input  wire logic                      stop,
    input  wire logic [cgpd_pkg::DIV_W-1:0] half,
    output logic                           clk_q,
    output logic                           fall_q,
    output logic                           parked
);
    logic [cgpd_pkg::DIV_W-1:0] cnt_q;
    logic                       wrap;

    assign wrap   = (cnt_q == half - 1'b1);
    assign parked = stop & ~clk_q;

    // Stops only from low so a high phase always completes
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else if (parked) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else if (wrap) begin
            cnt_q <= '0;
            clk_q <= ~clk_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Pulse in the cycle the output goes low
    always_ff @(posedge mclk) begin
        if (srst) begin
            fall_q <= 1'b0;
        end else begin
            fall_q <= ~parked & wrap & clk_q;
        end
    end
endmodule : cgpd_clk_div

// *** src/cgpd_top.sv ***
/*
 * Power-down sequencer for a multi-output clock generator in
 * differential host clock mode.
 * Assumes power_down_n is synchronous to mclk; pads and current
 * steering sit outside and follow host_q.
 */
`timescale 1ns/1ps
module cgpd_top #(
    parameter int PUP_CYC = cgpd_pkg::PUP_LAT_CYC
) (
    input  wire logic                        mclk,
    input  wire logic                        srst,
    input  wire logic                        power_down_n,
    input  wire logic [1:0]                  host_freq_sel,
    output cgpd_pkg::cgpd_host_pins_t        host_q,
    output logic [cgpd_pkg::N_OUT-1:0]       clk_out_q,
    output logic                             pd_active_q
);
    cgpd_pkg::cgpd_state_t             state_q;
    logic                              seen_low_q;
    logic [cgpd_pkg::LAT_W-1:0]        wake_cnt_q;
    logic [cgpd_pkg::DIV_W-1:0]        host_half;
    logic                              host_clk;
    logic                              host_fall;
    logic                              stop;
    logic [cgpd_pkg::N_OUT-1:0]        out_clk;
    logic [cgpd_pkg::N_OUT-1:0]        out_parked;

    assign stop = (state_q != cgpd_pkg::CGPD_RUN);

    // Frequency setting picks only the divide; entry path is shared
    always_comb begin
        host_half = cgpd_pkg::HOST_HALF_66;
        if (host_freq_sel == cgpd_pkg::SEL_100) begin
            host_half = cgpd_pkg::HOST_HALF_100;
        end else if (host_freq_sel == cgpd_pkg::SEL_133) begin
            host_half = cgpd_pkg::HOST_HALF_133;
        end else if (host_freq_sel == cgpd_pkg::SEL_200) begin
            host_half = cgpd_pkg::HOST_HALF_200;
        end
    end

    cgpd_clk_div u_host_div (
        .mclk   (mclk),
        .srst   (srst),
        .stop   (stop),
        .half   (host_half),
        .clk_q  (host_clk),
        .fall_q (host_fall),
        .parked ()
    );

    // One divider per non-host output
    genvar gi;
    generate
        for (gi = 0; gi < cgpd_pkg::N_OUT; gi++) begin : g_out
            cgpd_clk_div u_div (
                .mclk   (mclk),
                .srst   (srst),
                .stop   (stop),
                .half   (cgpd_pkg::OUT_HALF[gi*cgpd_pkg::DIV_W +:
                                            cgpd_pkg::DIV_W]),
                .clk_q  (out_clk[gi]),
                .fall_q (),
                .parked (out_parked[gi])
            );
        end
    endgenerate

    // Complement rises when true falls: sample power_down_n there
    always_ff @(posedge mclk) begin
        if (srst) begin
            seen_low_q <= 1'b0;
        end else if (state_q != cgpd_pkg::CGPD_RUN) begin
            seen_low_q <= 1'b0;
        end else if (host_fall) begin
            seen_low_q <= ~power_down_n;
        end
    end

    // Sequencer; a release during stopping goes straight to wake
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= cgpd_pkg::CGPD_RUN;
        end else begin
            case (state_q)
                cgpd_pkg::CGPD_RUN: begin
                    if (host_fall && seen_low_q && !power_down_n) begin
                        state_q <= cgpd_pkg::CGPD_STOPPING;
                    end
                end
                cgpd_pkg::CGPD_STOPPING: begin
                    if (power_down_n) begin
                        state_q <= cgpd_pkg::CGPD_WAKE;
                    end else if (&out_parked) begin
                        state_q <= cgpd_pkg::CGPD_DOWN;
                    end
                end
                cgpd_pkg::CGPD_DOWN: begin
                    if (power_down_n) begin
                        state_q <= cgpd_pkg::CGPD_WAKE;
                    end
                end
                cgpd_pkg::CGPD_WAKE: begin
                    if (wake_cnt_q == PUP_CYC[cgpd_pkg::LAT_W-1:0]) begin
                        state_q <= cgpd_pkg::CGPD_RUN;
                    end
                end
                default: begin
                    state_q <= cgpd_pkg::CGPD_RUN;
                end
            endcase
        end
    end

    // Wake latency counter, models oscillator and loop settling
    always_ff @(posedge mclk) begin
        if (srst || state_q != cgpd_pkg::CGPD_WAKE) begin
            wake_cnt_q <= '0;
        end else begin
            wake_cnt_q <= wake_cnt_q + 1'b1;
        end
    end

    // Host pair: true parked high at double current, complement released
    always_ff @(posedge mclk) begin
        if (srst) begin
            host_q <= '{t: 1'b0, c: 1'b1, c_oe_n: 1'b0, t_dbl_iref: 1'b0};
        end else if (stop) begin
            host_q <= '{t: 1'b1, c: 1'b0, c_oe_n: 1'b1,
                        t_dbl_iref: 1'b1};
        end else begin
            host_q <= '{t: host_clk, c: ~host_clk, c_oe_n: 1'b0,
                        t_dbl_iref: 1'b0};
        end
    end

    // Registered outputs keep pads glitch free
    always_ff @(posedge mclk) begin
        if (srst) begin
            clk_out_q   <= '0;
            pd_active_q <= 1'b0;
        end else begin
            clk_out_q   <= out_clk;
            pd_active_q <= (state_q == cgpd_pkg::CGPD_DOWN);
        end
    end

    // Checker only: run of low samples, rebuilt from the host pins and host_clk so
    // it does not lean on host_fall or seen_low_q
    localparam logic [1:0] LOW_RUN = 2'h2;
    logic [1:0]            low_run_q;

    always_ff @(posedge mclk) begin
        if (srst || stop) begin
            low_run_q <= '0;
        end else if (!host_q.c_oe_n && !host_q.c && !host_clk) begin
            if (power_down_n) begin
                low_run_q <= '0;
            end else if (low_run_q != LOW_RUN) begin
                low_run_q <= low_run_q + 2'h1;
            end
        end
    end

    // Delay bounds must be local names, not scoped ones
    localparam int QUIET_BOUND = cgpd_pkg::QUIET_MAX;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_second_low;
        host_fall && seen_low_q && !power_down_n;
    endsequence

    sequence s_enter;
        state_q == cgpd_pkg::CGPD_RUN ##1
        state_q == cgpd_pkg::CGPD_STOPPING;
    endsequence

    pd_entry_a: assert property (
        s_enter |-> $past(seen_low_q && host_fall && !power_down_n))
        else $error("power-down entered without two low samples");

    entry_any_freq_a: assert property (
        (state_q == cgpd_pkg::CGPD_RUN) and s_second_low |=>
        state_q == cgpd_pkg::CGPD_STOPPING)
        else $error("second low sample did not start power-down");

    outs_low_a: assert property (
        state_q == cgpd_pkg::CGPD_DOWN |=> clk_out_q == '0)
        else $error("non-host output not held low in power-down");

    no_rise_a: assert property (
        stop && !$past(stop) |=> ##1 !$rose(|clk_out_q) [*8])
        else $error("non-host output rose after stop request");

    host_park_a: assert property (
        stop |=> host_q.t && host_q.c_oe_n && host_q.t_dbl_iref)
        else $error("host pair not parked in power-down");

    quiet_bound_a: assert property (
        s_enter ##0 !power_down_n [*1] |->
        ##[0:QUIET_BOUND] (state_q != cgpd_pkg::CGPD_STOPPING))
        else $error("outputs did not go quiet in time");

    wake_bound_a: assert property (
        state_q == cgpd_pkg::CGPD_WAKE |->
        wake_cnt_q <= PUP_CYC[cgpd_pkg::LAT_W-1:0])
        else $error("power-up latency exceeded");

    full_period_a: assert property (
        $fell(stop) |-> ##1 (clk_out_q == '0) [*2])
        else $error("restart began with a short pulse");

    entry_two_low_a: assert property (
        s_enter |-> low_run_q == LOW_RUN)
        else $error("power-down entered before two low pin samples");

    host_restart_a: assert property (
        $fell(stop) |=> !host_q.t && !host_q.c_oe_n)
        else $error("host pair did not restart from a low phase");
endmodule : cgpd_top

// *** dv/cgpd_pm_model.sv ***
/* Power management partner model that drives power_down_n.
 * Assumes the bench drives req and glitch from the mclk rising edge. */
`timescale 1ns/1ps
module cgpd_pm_model (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic req,
    input  wire logic glitch,
    output logic      power_down_n
);
    // Level request, or a short low that should be ignored
    always_ff @(posedge mclk) begin
        if (srst) begin
            power_down_n <= 1'b1;
        end else begin
            power_down_n <= ~(req | glitch);
        end
    end
endmodule : cgpd_pm_model

// *** dv/tb_clock_gen_power_down.sv ***
/* Self-checking bench for the power-down sequencer.
 * Assumes a short power-up count; the partner model drives power_down_n. */
`timescale 1ns/1ps
module tb_clock_gen_power_down;
    localparam int PUP = 20;  // Short wake count keeps the run brief
    logic                       mclk, srst, req, glitch, power_down_n;
    logic [1:0]                 host_freq_sel;
    cgpd_pkg::cgpd_host_pins_t  host_q;
    logic [cgpd_pkg::N_OUT-1:0] clk_out_q;
    logic                       pd_active_q;
    int                         failures, checked, n;

    cgpd_pm_model PM (.mclk(mclk), .srst(srst), .req(req),
                      .glitch(glitch), .power_down_n(power_down_n));
    cgpd_top #(.PUP_CYC(PUP)) DUT (.mclk(mclk), .srst(srst),
        .power_down_n(power_down_n), .host_freq_sel(host_freq_sel),
        .host_q(host_q), .clk_out_q(clk_out_q), .pd_active_q(pd_active_q));

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic test_done;
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask : chk

    // Bounded wait for pd_active_q; a spent bound ends the run
    task automatic wait_pd(input logic lvl, input int lim);
        for (n = 0; n < lim && pd_active_q !== lvl; n++) @(posedge mclk) #1;
        if (n >= lim) begin
            failures++;
            test_done();
        end
    endtask : wait_pd

    task automatic do_reset(input logic [1:0] sel);
        @(posedge mclk);
        srst <= 1'b1;
        host_freq_sel <= sel;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk) #1;
        chk({4'h0, host_q}, 8'h04);
        chk({4'h0, clk_out_q}, 8'h00);
        chk({7'h0, pd_active_q}, 8'h00);
    endtask : do_reset

    // Full entry and release at one host setting
    task automatic run_entry(input logic [1:0] sel);
        do_reset(sel);
        repeat (40) @(posedge mclk);
        req <= 1'b1;
        @(posedge mclk) #1;
        wait_pd(1'b1, 600);
        repeat (60) @(posedge mclk);
        #1;
        chk({7'h0, host_q.t}, 8'h01);
        chk({7'h0, host_q.t_dbl_iref}, 8'h01);
        chk({7'h0, host_q.c_oe_n}, 8'h01);
        chk({4'h0, clk_out_q}, 8'h00);
        @(posedge mclk);
        req <= 1'b0;
        for (n = 0; n < PUP + 100 && clk_out_q[0] !== 1'b1; n++)
            @(posedge mclk) #1;
        chk({7'h0, n < PUP + 100}, 8'h01);
        if (n >= PUP + 100) begin
            test_done();
        end
        chk({7'h0, pd_active_q}, 8'h00);
        chk({7'h0, host_q.c_oe_n}, 8'h00);
        for (n = 0; n < 40 && clk_out_q[0] === 1'b1; n++) @(posedge mclk) #1;
        chk(8'(n), cgpd_pkg::OUT_HALF[7:0]);
        if (n >= 40) begin
            test_done();
        end
    endtask : run_entry

    // One low sample only must not start power-down
    task automatic run_glitch;
        logic seen;
        seen = 1'b0;
        do_reset(cgpd_pkg::SEL_66);
        repeat (20) @(posedge mclk);
        // Low for one host period: exactly one sample edge sees it
        glitch <= 1'b1;
        repeat (2 * cgpd_pkg::HOST_HALF_66) @(posedge mclk);
        glitch <= 1'b0;
        repeat (100) begin
            @(posedge mclk) #1;
            seen = seen | pd_active_q | host_q.c_oe_n;
        end
        chk({7'h0, seen}, 8'h00);
    endtask : run_glitch

    initial begin
        srst = 1'b1;
        req = 1'b0;
        glitch = 1'b0;
        host_freq_sel = cgpd_pkg::SEL_100;
        failures = 0;
        checked = 0;
        run_glitch();
        run_entry(cgpd_pkg::SEL_66);
        run_entry(cgpd_pkg::SEL_100);
        run_entry(cgpd_pkg::SEL_133);
        run_entry(cgpd_pkg::SEL_200);
        test_done();
    end
endmodule : tb_clock_gen_power_down
